// ==== hw/pcg_pkg.sv ====
// Constants and types shared by the PLL clock generator
package pcg_pkg;
	// Master clock rate and nominal VCO step
	localparam longint MCLK_HZ = 64'h0000_0000_0773_5940;
	localparam longint NOM_HZ = 64'h0000_0000_004B_0000;
	// Phase accumulator: VCO period is 2 * 2^ACC_W / increment cycles
	localparam int ACC_W = 20;
	localparam int INC_W = 22;
	localparam logic [INC_W-1:0] NOM_INC =
		INC_W'((NOM_HZ * (64'h1 << (ACC_W + 1))) / MCLK_HZ);
	localparam logic [INC_W-1:0] MAX_INC = 22'h0F_FFFF;
	// Filter steps for acquisition and tracking
	localparam logic [INC_W-1:0] ACQ_STEP = 22'h00_0040;
	localparam logic [INC_W-1:0] TRK_STEP = 22'h00_0004;
	// Programming register fields
	localparam int N_MSB = 7;
	localparam int N_LSB = 4;
	localparam int L_MSB = 3;
	localparam int L_LSB = 0;
	// Source change wait, in cycles of each input clock
	localparam logic [1:0] SW_WAIT = 2'h3;
	// Lock detector window in reference cycles and tolerances
	localparam logic [7:0] LD_WIN = 8'h10;
	localparam logic [7:0] TRK_TOL = 8'h02;
	localparam logic [7:0] UNT_TOL = 8'h04;
	localparam logic [7:0] LCK_TOL = 8'h01;
	localparam logic [7:0] UNL_TOL = 8'h02;
	// Crystal half period in master clock cycles
	localparam int XTAL_HALF_DEF = 16;

	typedef enum {SEL_XTAL, SEL_TO_VCO, SEL_VCO, SEL_TO_XTAL} pcg_sel_t;

	typedef struct packed {
		logic pll_on;
		logic base_clock_select;
	} pcg_wr_t;

	typedef struct packed {
		logic pll_on;
		logic base_clock_select;
		logic trk;
		logic lock;
	} pcg_stat_t;
endpackage

// ==== hw/pcg_top.sv ====
// PLL clock generator: crystal, loop, lock detector and base clock selector
// Operation
// [RQ1] Base clock is selected clock divided by two
// [RQ2] Crystal runs only while oscillator enable high
// [RQ3] Crystal clock buffered into same-rate reference clocks
// [RQ4] Feedback clock is VCO divided by N
// [RQ5] Loop settles at N times reference frequency
// [RQ6] Phase detector pulse width/direction follows phase error
// [RQ7] Lock detector compares feedback and reference frequencies
// [RQ8] VCO centre is nominal step times L
// [RQ9] Acquisition mode shows tracking bit clear
// [RQ10] Tracking mode makes only small corrections
// [RQ11] Automatic mode switches filter mode by itself
// [RQ12] Interrupt on lock entry and on lock exit
// [RQ13] Software selects VCO only after lock set; code checks only that pll_on is set, not lock
// [RQ14] Source change waits three cycles each, output held
// [RQ15] Refuse VCO select off, off while selected, both
// [RQ16] N zero acts as one; L zero disables
// [RQ17] Upper nibble is N, lower nibble is L
`timescale 1ns/1ns
module pcg_top #(
	parameter int XTAL_HALF = pcg_pkg::XTAL_HALF_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// System integration side
	input wire logic osc_enable_from_sysint,
	output logic base_clock_out,
	// Control
	input wire logic ctl_wr,
	input pcg_pkg::pcg_wr_t ctl_data,
	input wire logic auto_mode,
	input wire logic acq_manual,
	input wire logic irq_enable,
	input wire logic [7:0] loop_programming_reg,
	// Status
	output pcg_pkg::pcg_stat_t status,
	output logic lock_irq,
	// Internal clocks brought out
	output logic crystal_clock,
	output logic loop_reference_clock,
	output logic final_reference_clock,
	output logic loop_osc_clock,
	output logic divided_feedback_clock,
	// Loop filter model
	output logic pd_up,
	output logic pd_dn,
	output logic [pcg_pkg::INC_W-1:0] filter_capacitor_pin
);
	import pcg_pkg::*;

	if (XTAL_HALF < 2 || XTAL_HALF > 65535)
	begin : g_chk
		$error("XTAL_HALF out of range");
	end

	logic [3:0] mult_n, range_l, nmax;
	logic l_zero, pll_run, on_chg, bcs_chg;
	logic [15:0] xcnt_q;
	logic xtal_q, xrise, lref_q, rdv_q;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W:0] acc_sum;
	logic vco_q, vrise;
	logic [INC_W-1:0] inc_q, centre, dbl, lo, hi, step;
	logic [INC_W:0] up_sum;
	logic [3:0] fcnt_q;
	logic fb_tick, fdv_q, up_q, dn_q;
	logic [7:0] wcnt_q, fbc_q, fb_now, mag;
	logic win_end, trk_q, trk_d, lock_q, lock_d, irq_q;
	logic pll_on_q, bcs_q;
	pcg_sel_t sel_q;
	logic [1:0] xw_q, vw_q;
	logic busy, sw_done, base_q;

	assign mult_n = loop_programming_reg[N_MSB:N_LSB]; // [RQ17]
	assign range_l = loop_programming_reg[L_MSB:L_LSB]; // [RQ17]
	assign l_zero = (range_l == 4'h0);
	assign pll_run = pll_on_q && !l_zero; // [RQ16]
	assign nmax = (mult_n == 4'h0) ? 4'h0 : mult_n - 4'h1; // [RQ16]

	// Crystal oscillator as a divider of the master clock
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			xcnt_q <= 16'h0000;
			xtal_q <= 1'b0;
		end
		else if (!osc_enable_from_sysint)
		begin
			xcnt_q <= 16'h0000; // [RQ2]
			xtal_q <= 1'b0; // [RQ2]
		end
		else if (xcnt_q == 16'(XTAL_HALF - 1))
		begin
			xcnt_q <= 16'h0000;
			xtal_q <= ~xtal_q;
		end
		else
			xcnt_q <= xcnt_q + 16'h0001;
	end

	assign xrise = osc_enable_from_sysint && !xtal_q &&
		xcnt_q == 16'(XTAL_HALF - 1);

	// Buffered reference and final reference pulse
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			lref_q <= 1'b0;
			rdv_q <= 1'b0;
		end
		else
		begin
			lref_q <= xtal_q; // [RQ3]
			rdv_q <= xrise; // [RQ3]
		end
	end

	// VCO range around the centre frequency
	assign centre = INC_W'(range_l * NOM_INC); // [RQ8]
	assign dbl = {centre[INC_W-2:0], 1'b0};
	assign hi = (dbl > MAX_INC) ? MAX_INC : dbl;
	assign lo = {1'b0, centre[INC_W-1:1]};
	assign step = trk_q ? TRK_STEP : ACQ_STEP; // [RQ10]
	assign up_sum = {1'b0, inc_q} + {1'b0, step};

	// Loop filter: the control word stands for the capacitor voltage
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			inc_q <= '0;
		else if (!pll_run)
			inc_q <= centre; // [RQ8]
		else if (up_q && !dn_q)
			inc_q <= (up_sum > {1'b0, hi}) ? hi : up_sum[INC_W-1:0];
		else if (dn_q && !up_q)
			inc_q <= (inc_q < lo + step) ? lo : inc_q - step;
	end

	// VCO as a phase accumulator
	assign acc_sum = {1'b0, acc_q} + (ACC_W + 1)'(inc_q);
	assign vrise = pll_run && acc_sum[ACC_W] && !vco_q;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			acc_q <= '0;
			vco_q <= 1'b0;
		end
		else if (!pll_run)
		begin
			acc_q <= '0; // [RQ16]
			vco_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_sum[ACC_W-1:0];
			vco_q <= vco_q ^ acc_sum[ACC_W];
		end
	end

	// Modulo feedback divider; >= so a smaller N takes effect at once
	assign fb_tick = vrise && fcnt_q >= nmax; // [RQ4]

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			fcnt_q <= 4'h0;
		else if (!pll_run)
			fcnt_q <= 4'h0;
		else if (vrise)
			fcnt_q <= (fcnt_q >= nmax) ? 4'h0 : fcnt_q + 4'h1; // [RQ4]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			fdv_q <= 1'b0;
		else
			fdv_q <= fb_tick;
	end

	// Phase-frequency detector driving the filter toward N * f_ref
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
		end
		else if (!pll_run || ((up_q || xrise) && (dn_q || fb_tick)))
		begin
			up_q <= 1'b0; // [RQ6]
			dn_q <= 1'b0; // [RQ6]
		end
		else
		begin
			up_q <= up_q || xrise; // [RQ5] [RQ6]
			dn_q <= dn_q || fb_tick; // [RQ5] [RQ6]
		end
	end

	// Lock detector: feedback edges counted over a reference window
	assign win_end = pll_run && xrise && wcnt_q == LD_WIN - 8'h01;
	assign fb_now = (fb_tick && fbc_q != 8'hFF) ? fbc_q + 8'h01 : fbc_q;
	assign mag = (fb_now > LD_WIN) ? fb_now - LD_WIN : LD_WIN - fb_now;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wcnt_q <= 8'h00;
			fbc_q <= 8'h00;
		end
		else if (!pll_run || win_end)
		begin
			wcnt_q <= 8'h00;
			fbc_q <= 8'h00;
		end
		else
		begin
			if (xrise)
				wcnt_q <= wcnt_q + 8'h01;
			fbc_q <= fb_now; // [RQ7]
		end
	end

	always_comb
	begin
		trk_d = trk_q;
		lock_d = lock_q;
		if (!pll_run)
		begin
			trk_d = 1'b0;
			lock_d = 1'b0;
		end
		else if (!auto_mode)
		begin
			trk_d = acq_manual;
			lock_d = 1'b0;
		end
		else if (win_end)
		begin
			if (mag <= TRK_TOL)
				trk_d = 1'b1; // [RQ7] [RQ11]
			else if (mag > UNT_TOL)
				trk_d = 1'b0; // [RQ9] [RQ11]
			if (mag <= LCK_TOL)
				lock_d = 1'b1; // [RQ7]
			else if (mag > UNL_TOL)
				lock_d = 1'b0; // [RQ7]
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			trk_q <= 1'b0;
			lock_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			trk_q <= trk_d;
			lock_q <= lock_d;
			irq_q <= irq_enable && auto_mode && (lock_d != lock_q); // [RQ12]
		end
	end

	// Control writes with interlocks
	assign on_chg = ctl_data.pll_on != pll_on_q;
	assign bcs_chg = ctl_data.base_clock_select != bcs_q;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			pll_on_q <= 1'b0;
		else if (ctl_wr && on_chg && !bcs_chg &&
			(ctl_data.pll_on || (!bcs_q && sel_q == SEL_XTAL)))
			pll_on_q <= ctl_data.pll_on; // [RQ15]
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			bcs_q <= 1'b0;
		else if (l_zero)
			bcs_q <= 1'b0; // [RQ16]
		else if (ctl_wr && !on_chg && (pll_on_q || !ctl_data.base_clock_select))
			bcs_q <= ctl_data.base_clock_select; // [RQ1] [RQ13] [RQ15]
	end

	// Base clock selector with transition control
	assign busy = (sel_q == SEL_TO_VCO) || (sel_q == SEL_TO_XTAL);
	assign sw_done = xw_q == SW_WAIT && (vw_q == SW_WAIT || !pll_run);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sel_q <= SEL_XTAL;
		else
			case (sel_q)
				SEL_XTAL:
					if (bcs_q)
						sel_q <= SEL_TO_VCO;
				SEL_TO_VCO:
					if (!bcs_q)
						sel_q <= SEL_XTAL;
					else if (sw_done)
						sel_q <= SEL_VCO; // [RQ14]
				SEL_VCO:
					if (!bcs_q)
						sel_q <= SEL_TO_XTAL;
				SEL_TO_XTAL:
					if (sw_done)
						sel_q <= SEL_XTAL; // [RQ14]
				default:
					sel_q <= SEL_XTAL;
			endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			xw_q <= 2'h0;
			vw_q <= 2'h0;
		end
		else if (!busy)
		begin
			xw_q <= 2'h0;
			vw_q <= 2'h0;
		end
		else
		begin
			if (xrise && xw_q != SW_WAIT)
				xw_q <= xw_q + 2'h1; // [RQ14]
			if (vrise && vw_q != SW_WAIT)
				vw_q <= vw_q + 2'h1; // [RQ14]
		end
	end

	// Divide the chosen source by two; frozen while switching
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			base_q <= 1'b0;
		else if (sel_q == SEL_VCO)
			base_q <= base_q ^ vrise; // [RQ1]
		else if (sel_q == SEL_XTAL)
			base_q <= base_q ^ xrise; // [RQ1]
	end

	assign base_clock_out = base_q;
	assign status = '{pll_on: pll_on_q, base_clock_select: bcs_q, trk: trk_q,
		lock: lock_q};
	assign lock_irq = irq_q;
	assign crystal_clock = xtal_q;
	assign loop_reference_clock = lref_q;
	assign final_reference_clock = rdv_q;
	assign loop_osc_clock = vco_q;
	assign divided_feedback_clock = fdv_q;
	assign pd_up = up_q;
	assign pd_dn = dn_q;
	assign filter_capacitor_pin = inc_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence sw_begin;
		sel_q == SEL_XTAL && bcs_q;
	endsequence

	// A legal abort may drop busy early; the VCO must still not be reached
	sequence held_long;
		(sel_q != SEL_VCO) [*8];
	endsequence

	osc_gate_a: assert property (!osc_enable_from_sysint |=> !xtal_q) // [RQ2]
		else $error("crystal ran while disabled");
	base_hold_a: assert property (busy |=> $stable(base_q)) // [RQ14]
		else $error("base clock moved during switch");
	sw_wait_a: assert property (sw_begin |=> held_long) // [RQ14]
		else $error("source switch too short");
	sel_refuse_a: assert property ( // [RQ15]
		ctl_wr && ctl_data.base_clock_select && !pll_on_q |=> !bcs_q)
		else $error("VCO selected with loop off");
	both_refuse_a: assert property ( // [RQ15]
		ctl_wr && on_chg && bcs_chg |=> $stable(pll_on_q))
		else $error("loop and select changed together");
	zero_range_a: assert property (l_zero |=> !bcs_q && !vco_q) // [RQ16]
		else $error("range zero did not disable loop");
	acq_clear_a: assert property ( // [RQ9]
		auto_mode && win_end && mag > UNT_TOL |=> !trk_q)
		else $error("tracking bit set out of tolerance");
	irq_pair_a: assert property (lock_irq == ($changed(lock_q) && // [RQ12]
		$past(irq_enable) && $past(auto_mode)))
		else $error("lock interrupt mismatch");
	pfd_up_a: assert property ( // [RQ6]
		pll_run && xrise && !fb_tick && !dn_q |=> up_q && !dn_q)
		else $error("phase detector missed reference edge");
endmodule

// ==== verif/pcg_sim_model.sv ====
// System integration side model: crystal enable and base clock edge count
`timescale 1ns/1ns
module pcg_sim_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Bench control
	input wire logic run,
	input wire logic clr,
	// Clock generator side
	input wire logic base_clock_out,
	output logic osc_enable_from_sysint,
	output int n_edges
);
	logic last_q;
	// Enable held low through reset
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			osc_enable_from_sysint <= 1'b0;
		else
			osc_enable_from_sysint <= run;
	// Count base clock toggles
	always_ff @(posedge mclk)
	begin
		last_q <= base_clock_out;
		if (clr)
			n_edges <= 0;
		else if (last_q !== base_clock_out)
			n_edges <= n_edges + 1;
	end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the PLL clock generator
`timescale 1ns/1ns
module testbench;
	import pcg_pkg::*;
	localparam int XH = 16;
	localparam int RP = 2 * XH;
	logic mclk, rst, ctl_wr, auto_mode, acq_manual, irq_enable;
	logic run, clr, base_clock_out, osc_en, lock_irq;
	logic xc, lr, fr, vc, fd, pu, pdn, xc_d, vc_d;
	int n_xr, n_fr, n_vr, n_fd, n_pu, n_pd;
	logic [7:0] prog;
	logic [INC_W-1:0] fw;
	pcg_wr_t wd;
	pcg_stat_t st;
	int n_edges, n_fail, tests_run, m_on, m_bcs, k, nirq, n, l;
	logic [31:0] rs;
	pcg_top #(.XTAL_HALF(XH)) dut (.mclk(mclk), .rst(rst),
		.osc_enable_from_sysint(osc_en), .base_clock_out(base_clock_out),
		.ctl_wr(ctl_wr), .ctl_data(wd), .auto_mode(auto_mode),
		.acq_manual(acq_manual), .irq_enable(irq_enable),
		.loop_programming_reg(prog), .status(st), .lock_irq(lock_irq),
		.crystal_clock(xc), .loop_reference_clock(lr),
		.final_reference_clock(fr), .loop_osc_clock(vc),
		.divided_feedback_clock(fd), .pd_up(pu), .pd_dn(pdn),
		.filter_capacitor_pin(fw));
	pcg_sim_model sim (.mclk(mclk), .rst(rst), .run(run), .clr(clr),
		.base_clock_out(base_clock_out), .osc_enable_from_sysint(osc_en),
		.n_edges(n_edges));
	initial
	begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask
	task automatic end_sim;
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Write with acceptance worked out by the bench model
	task automatic wr(input logic on, input logic base_clock_select);
		logic ok;
		ok = !(on != m_on && base_clock_select != m_bcs);
		if (base_clock_select && !m_bcs && (!m_on || prog[3:0] == 4'h0))
			ok = 0;
		if (!on && m_on && m_bcs)
			ok = 0;
		if (ok)
		begin
			m_on = on;
			m_bcs = base_clock_select;
		end
		wd = '{pll_on: on, base_clock_select: base_clock_select};
		ctl_wr = 1;
		tick(1);
		ctl_wr = 0;
		tick(1);
		chk(st.pll_on, m_on);
		chk(st.base_clock_select, m_bcs);
	endtask
	// Base clock toggles over sixteen reference periods
	task automatic meas(input int lo, input int hi);
		clr = 1;
		tick(1);
		clr = 0;
		tick(16 * RP);
		chk(n_edges >= lo && n_edges <= hi, 1);
	endtask
	// Internal clock counters, sampled mid-cycle where outputs are settled
	always @(negedge mclk)
	begin
		if (rst === 1'b0)
			chk(lr, xc_d);
		if (clr)
		begin
			n_xr = 0;
			n_fr = 0;
			n_vr = 0;
			n_fd = 0;
			n_pu = 0;
			n_pd = 0;
		end
		else
		begin
			if (xc && !xc_d)
				n_xr++;
			if (vc && !vc_d)
				n_vr++;
			if (fr)
				n_fr++;
			if (fd)
				n_fd++;
			if (pu)
				n_pu++;
			if (pdn)
				n_pd++;
		end
		xc_d = xc;
		vc_d = vc;
	end
	initial
	begin
		#(8 * 90000);
		n_fail++;
		end_sim;
	end
	initial
	begin
		rst = 1;
		ctl_wr = 0;
		wd = '0;
		auto_mode = 0;
		acq_manual = 0;
		irq_enable = 1;
		run = 0;
		clr = 0;
		prog = 8'h00;
		n_fail = 0;
		tests_run = 0;
		m_on = 0;
		m_bcs = 0;
		nirq = 0;
		rs = 32'he79c;
		tick(16);
		chk(st, 4'h0);
		rst = 0;
		meas(0, 0);
		chk(n_xr, 0);
		chk(n_pu + n_pd, 0);
		run = 1;
		tick(4);
		meas(15, 17);
		chk(n_xr >= 15 && n_xr <= 17, 1);
		chk(n_fr >= 15 && n_fr <= 17, 1);
		for (k = 0; k < 8; k++)
		begin
			rs = xs(rs);
			prog = {rs[7:4], 4'h0};
			wr(rs[8], rs[9]);
		end
		wr(0, 0);
		n = 2 + rs[17:0] % 3;
		l = (n == 4) ? 3 : 2;
		prog = {n[3:0], l[3:0]};
		tick(2);
		chk(fw, INC_W'(l * NOM_INC));
		wr(0, 1);
		wr(1, 1);
		wr(1, 0);
		tick(2);
		chk(st.trk, 0);
		auto_mode = 1;
		for (k = 0; k < 30000 && st.lock !== 1'b1; k++)
		begin
			tick(1);
			if (lock_irq === 1'b1)
				nirq++;
		end
		chk(st.lock, 1);
		chk(st.trk, 1);
		chk(nirq, 1);
		wr(1, 1);
		clr = 1;
		tick(1);
		clr = 0;
		tick(2 * RP - 4);
		chk(n_edges, 0);
		tick(4 * RP);
		wr(0, 1);
		wr(0, 0);
		meas(16 * n - 2, 16 * n + 2);
		chk(n_vr >= 16 * n - 2 && n_vr <= 16 * n + 2, 1);
		chk(n_fd >= 15 && n_fd <= 17, 1);
		wr(1, 0);
		tick(6 * RP);
		meas(15, 17);
		prog = 8'hF2;
		for (k = 0; k < 8000 && st.lock !== 1'b0; k++)
		begin
			tick(1);
			if (lock_irq === 1'b1)
				nirq++;
		end
		chk(st.lock, 0);
		chk(nirq, 2);
		meas(15, 17);
		chk(n_pu > n_pd, 1);
		auto_mode = 0;
		acq_manual = 1;
		tick(3);
		chk(st.trk, 1);
		chk(st.lock, 0);
		prog = 8'h02;
		meas(15, 17);
		chk(n_fd, n_vr);
		chk(n_vr > 0, 1);
		wr(0, 0);
		end_sim;
	end
endmodule
